// ---- logic/atc_pkg.sv ----
/*
 * atc_pkg: constants and types shared by the trigger control block.
 * assumes: included in compile order before every logic/ module.
 */
package atc_pkg;
	// -----------------------------------------------------------------
	// register map (byte addresses, one aligned 32-bit word each)
	// -----------------------------------------------------------------
	localparam logic [5:0] ADDR_CTRL = 6'h00;
	localparam logic [5:0] ADDR_CFG = 6'h04;
	localparam logic [5:0] ADDR_DELAY = 6'h08;
	localparam logic [5:0] ADDR_TOTAL = 6'h0C;
	localparam logic [5:0] ADDR_THRESH = 6'h10;
	localparam logic [5:0] ADDR_STATUS = 6'h14;
	localparam logic [5:0] ADDR_COUNT = 6'h18;
	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int CFG_SRC_LSB = 0;
	localparam int CFG_EDGE_BIT = 2;
	localparam int CFG_ACT_BIT = 3;
	localparam int CFG_CHAN_LSB = 4;
	localparam int CFG_RANGE_LSB = 8;
	// -----------------------------------------------------------------
	// reset values and the unmapped read value
	// -----------------------------------------------------------------
	localparam logic [31:0] DELAY_RST = 32'h0000_0001;
	localparam logic [31:0] TOTAL_RST = 32'h0000_0000;
	localparam logic [15:0] THRESH_RST = 16'h0000;
	localparam logic [31:0] BUS_UNMAPPED = 32'h0000_0000;
	// -----------------------------------------------------------------
	// encodings
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_NONE = 2'h0,
		SRC_ANALOG = 2'h1,
		SRC_PIN = 2'h2
	} atc_src_t;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ARMED = 5'h02,
		ST_WAIT = 5'h04,
		ST_RUN = 5'h08,
		ST_TAIL = 5'h10
	} atc_state_t;
endpackage

// ---- logic/atc_skid.sv ----
/*
 * atc_skid: two-entry buffer with valid/ready on both sides.
 * assumes: same clock both sides; in_ready low stalls the source.
 */
`timescale 1ns/100ps
module atc_skid #(
	parameter int WIDTH = 16
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	// -----------------------------------------------------------------
	// storage
	// -----------------------------------------------------------------
	logic [WIDTH-1:0] mem_q [2]; // two entries
	logic [WIDTH-1:0] mem_d [2];
	logic [1:0] cnt_q; // occupancy 0..2
	logic [1:0] cnt_d;
	logic rd_q; // read pointer
	logic rd_d;
	logic push;
	logic pop;
	logic wr_ptr;

	// next state: push at tail, pop at head
	always_comb begin
		push = in_valid && (cnt_q != 2'h2);
		pop = (cnt_q != 2'h0) && out_ready;
		wr_ptr = rd_q ^ cnt_q[0];
		mem_d = mem_q;
		if (push) begin
			mem_d[wr_ptr] = in_data;
		end
		rd_d = pop ? ~rd_q : rd_q;
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	// registers only
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			cnt_q <= 2'h0;
			rd_q <= 1'b0;
		end else begin
			mem_q <= mem_d;
			cnt_q <= cnt_d;
			rd_q <= rd_d;
		end
	end

	assign in_ready = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem_q[rd_q];
endmodule

// ---- logic/atc_sync.sv ----
/*
 * atc_sync: three-stage pin synchroniser with agreement filter.
 * assumes: pin is asynchronous to clk_sys; output is a filtered level.
 */
`timescale 1ns/100ps
module atc_sync (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic pin,
	output logic level
);
	// -----------------------------------------------------------------
	// chain
	// -----------------------------------------------------------------
	logic s1_q; // metastable stage, only read by s2
	logic s2_q;
	logic s3_q;
	logic level_q;
	logic level_d;

	// level changes only once stage two and three agree
	always_comb begin
		level_d = level_q;
		if (s2_q == s3_q) begin
			level_d = s3_q;
		end
	end

	// registers only
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
		end
	end

	assign level = level_q;
endmodule

// ---- logic/atc_top.sv ----
/*
 * atc_top: acquisition trigger control with Avalon-MM register slave.
 * holds the trigger source, edge, action and delay settings and gates
 * sample strobes into converter starts; samples flow through a
 * two-entry buffer to the downstream sink.
 * assumes: sample_strobe is a one-cycle pulse from on-chip clock logic;
 * analog samples are signed 16-bit codes valid with sample_strobe;
 * outside_event_pin is asynchronous.
 */
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
module atc_top #(
	parameter int NCHAN = 8,
	parameter int DW = 16
) (
	input wire logic clk_sys,
	input wire logic nrst,
	// avalon-mm slave
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// acquisition side
	input wire logic outside_event_pin,
	input wire logic sample_strobe,
	input wire logic [NCHAN*DW-1:0] analog_channel_source,
	output logic convert_start,
	output logic acq_active,
	output logic [DW-1:0] sample_data,
	output logic sample_valid,
	input wire logic sample_ready
);
	// -----------------------------------------------------------------
	// register state
	// -----------------------------------------------------------------
	logic [31:0] cfg_q, cfg_d; // source, edge, action, channel, range
	logic [31:0] delay_q, delay_d; // trigger delay count
	logic [31:0] total_q, total_d; // total samples, zero is unlimited
	logic [15:0] thresh_q, thresh_d; // threshold in millivolts, signed
	logic [31:0] rdata_q, rdata_d;
	logic ack_q, ack_d; // one-cycle answer phase
	logic start_cmd, stop_cmd;
	logic [31:0] wmask;

	// -----------------------------------------------------------------
	// acquisition state
	// -----------------------------------------------------------------
	atc_pkg::atc_state_t st_q, st_d;
	logic [31:0] dcnt_q, dcnt_d; // delay counter
	logic [31:0] scnt_q, scnt_d; // samples taken this run
	logic trig_seen_q, trig_seen_d; // first trigger latched
	logic pin_prev_q, pin_prev_d;
	logic above_q, above_d; // analog side of threshold last strobe
	logic above_ok_q, above_ok_d; // above_q valid after a strobe
	logic pin_lvl;
	logic trig_evt;
	logic window;
	logic fire;
	logic buf_ready;
	logic above_now;
	logic [DW-1:0] chan_val;
	logic [DW+1:0] thr_code;
	logic [2:0] chan_sel;
	logic [1:0] range_sel;
	atc_pkg::atc_src_t src;

	// -----------------------------------------------------------------
	// input synchroniser for the trigger pin
	// -----------------------------------------------------------------
	atc_sync u_sync (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.pin(outside_event_pin),
		.level(pin_lvl)
	);

	// -----------------------------------------------------------------
	// output buffer; a full buffer holds off the converter
	// -----------------------------------------------------------------
	atc_skid #(.WIDTH(DW)) u_buf (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.in_valid(fire),
		.in_ready(buf_ready),
		.in_data(chan_val),
		.out_valid(sample_valid),
		.out_ready(sample_ready),
		.out_data(sample_data)
	);

	// -----------------------------------------------------------------
	// register file and bus next values
	// -----------------------------------------------------------------
	always_comb begin
		wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
			{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		cfg_d = cfg_q;
		delay_d = delay_q;
		total_d = total_q;
		thresh_d = thresh_q;
		rdata_d = rdata_q;
		start_cmd = 1'b0;
		stop_cmd = 1'b0;
		// answer one cycle after the request, then drop it
		ack_d = (avs_read || avs_write) && !ack_q;
		// a write lands on the edge that sees waitrequest low, never on
		// the wait edge, so a master that is still waiting changes nothing
		if (avs_write && ack_q) begin
			case (avs_address)
				atc_pkg::ADDR_CTRL: begin
					start_cmd = avs_byteenable[0] && avs_writedata[atc_pkg::CTRL_START_BIT];
					stop_cmd = avs_byteenable[0] && avs_writedata[atc_pkg::CTRL_STOP_BIT];
				end
				atc_pkg::ADDR_CFG: cfg_d = (cfg_q & ~wmask) | (avs_writedata & wmask);
				atc_pkg::ADDR_DELAY: begin
					delay_d = (delay_q & ~wmask) | (avs_writedata & wmask);
					if (delay_d == 32'h0000_0000) begin
						delay_d = atc_pkg::DELAY_RST;
					end
				end
				atc_pkg::ADDR_TOTAL: total_d = (total_q & ~wmask) | (avs_writedata & wmask);
				atc_pkg::ADDR_THRESH: thresh_d = (thresh_q & ~wmask[15:0])
					| (avs_writedata[15:0] & wmask[15:0]);
				default: begin
					// writes elsewhere are dropped
				end
			endcase
		end
		if (avs_read && !ack_q) begin
			case (avs_address)
				atc_pkg::ADDR_CFG: rdata_d = cfg_q;
				atc_pkg::ADDR_DELAY: rdata_d = delay_q;
				atc_pkg::ADDR_TOTAL: rdata_d = total_q;
				atc_pkg::ADDR_THRESH: rdata_d = {16'h0000, thresh_q};
				atc_pkg::ADDR_STATUS: rdata_d = {26'h0, trig_seen_q, st_q};
				atc_pkg::ADDR_COUNT: rdata_d = scnt_q;
				default: rdata_d = atc_pkg::BUS_UNMAPPED; // ctrl and holes read zero
			endcase
		end
	end

	// bus registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cfg_q <= 32'h0000_0000;
			delay_q <= atc_pkg::DELAY_RST;
			total_q <= atc_pkg::TOTAL_RST;
			thresh_q <= atc_pkg::THRESH_RST;
			rdata_q <= 32'h0000_0000;
			ack_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			delay_q <= delay_d;
			total_q <= total_d;
			thresh_q <= thresh_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
		end
	end

	// combinational wait: exactly one wait cycle for every access
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign avs_readdata = rdata_q;

	// -----------------------------------------------------------------
	// trigger detection
	// -----------------------------------------------------------------
	always_comb begin
		src = atc_pkg::atc_src_t'(cfg_q[atc_pkg::CFG_SRC_LSB +: 2]);
		chan_sel = cfg_q[atc_pkg::CFG_CHAN_LSB +: 3];
		range_sel = cfg_q[atc_pkg::CFG_RANGE_LSB +: 2];
		chan_val = analog_channel_source[chan_sel*DW +: DW];
		// code = mv * 32768 / (9800 >> range), approximated as (mv*107 >>> 5) << range, i.e. mv*3.34375 << range
		thr_code = (DW + 2)'(($signed(thresh_q) * 32'sd107) >>> 5) <<< range_sel;
		above_now = $signed({{2{chan_val[DW-1]}}, chan_val}) > $signed(thr_code);
		above_d = sample_strobe ? above_now : above_q;
		above_ok_d = (st_q == atc_pkg::ST_IDLE) ? 1'b0 : (above_ok_q | sample_strobe);
		pin_prev_d = pin_lvl;
		trig_evt = 1'b0;
		case (src)
			atc_pkg::SRC_PIN: trig_evt = cfg_q[atc_pkg::CFG_EDGE_BIT]
				? (pin_prev_q && !pin_lvl) : (!pin_prev_q && pin_lvl);
			atc_pkg::SRC_ANALOG: trig_evt = sample_strobe && above_ok_q &&
				(cfg_q[atc_pkg::CFG_EDGE_BIT] ? (above_q && !above_now)
				: (!above_q && above_now));
			default: trig_evt = 1'b0;
		endcase
	end

	// -----------------------------------------------------------------
	// acquisition sequencer
	// -----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		dcnt_d = dcnt_q;
		scnt_d = scnt_q;
		trig_seen_d = trig_seen_q;
		window = (st_q == atc_pkg::ST_RUN) || (st_q == atc_pkg::ST_TAIL);
		fire = window && sample_strobe && buf_ready;
		if (fire) begin
			scnt_d = scnt_q + 32'h1;
		end
		case (st_q)
			atc_pkg::ST_IDLE: begin
				if (start_cmd) begin
					scnt_d = 32'h0;
					trig_seen_d = 1'b0;
					dcnt_d = delay_q;
					// no source means start at once
					if (src == atc_pkg::SRC_NONE || cfg_q[atc_pkg::CFG_ACT_BIT]) begin
						st_d = atc_pkg::ST_RUN;
					end else begin
						st_d = atc_pkg::ST_ARMED;
					end
				end
			end
			atc_pkg::ST_ARMED: begin
				if (trig_evt) begin
					trig_seen_d = 1'b1;
					// the strobe after the trigger is the first delay pulse and
					// converts itself, so a count of one leaves nothing to wait for
					if (delay_q <= 32'h1) begin
						st_d = atc_pkg::ST_RUN;
					end else begin
						dcnt_d = delay_q - 32'h1;
						st_d = atc_pkg::ST_WAIT;
					end
				end
			end
			atc_pkg::ST_WAIT: begin
				// the strobe ending the count opens the window for the next
				if (sample_strobe) begin
					dcnt_d = dcnt_q - 32'h1;
					if (dcnt_q <= 32'h1) begin
						st_d = atc_pkg::ST_RUN;
					end
				end
			end
			atc_pkg::ST_RUN: begin
				if (src != atc_pkg::SRC_NONE && cfg_q[atc_pkg::CFG_ACT_BIT]
					&& !trig_seen_q && trig_evt) begin
					trig_seen_d = 1'b1;
					st_d = atc_pkg::ST_TAIL;
				end else if ((src == atc_pkg::SRC_NONE || !cfg_q[atc_pkg::CFG_ACT_BIT])
					&& total_q != 32'h0 && scnt_d >= total_q) begin
					st_d = atc_pkg::ST_IDLE;
				end
			end
			atc_pkg::ST_TAIL: begin
				// count delay conversions; sink keeps the latest total
				if (fire) begin
					dcnt_d = dcnt_q - 32'h1;
					if (dcnt_q <= 32'h1) begin
						st_d = atc_pkg::ST_IDLE;
					end
				end
			end
			default: st_d = atc_pkg::ST_IDLE;
		endcase
		if (stop_cmd) begin
			st_d = atc_pkg::ST_IDLE;
		end
	end

	// sequencer registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_q <= atc_pkg::ST_IDLE;
			dcnt_q <= 32'h0;
			scnt_q <= 32'h0;
			trig_seen_q <= 1'b0;
			pin_prev_q <= 1'b0;
			above_q <= 1'b0;
			above_ok_q <= 1'b0;
		end else begin
			st_q <= st_d;
			dcnt_q <= dcnt_d;
			scnt_q <= scnt_d;
			trig_seen_q <= trig_seen_d;
			pin_prev_q <= pin_prev_d;
			above_q <= above_d;
			above_ok_q <= above_ok_d;
		end
	end

	// both stay combinational so the accepted strobe is not delayed a cycle
	assign convert_start = fire;
	assign acq_active = window;
endmodule

// ---- test/adc_trigger_control_tb.sv ----
/*
 * adc_trigger_control_tb: scenario bench for atc_top.
 * assumes: atc_source as far side; samples drained unless stalled.
 */
`timescale 1ns/100ps
module adc_trigger_control_tb;
	logic clk_sys, nrst, avs_read, avs_write, strobe_en, pin_level, sample_ready;
	logic avs_waitrequest, outside_event_pin, sample_strobe, convert_start, acq_active;
	logic sample_valid;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [127:0] analog_channel_source;
	logic [15:0] sample_data, ch_level;
	int fail_count, check_count, conv_n, b;
	atc_top i_dut (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .outside_event_pin,
		.sample_strobe, .analog_channel_source, .convert_start, .acq_active, .sample_data,
		.sample_valid, .sample_ready);
	atc_source i_src (.clk_sys, .nrst, .strobe_en, .pin_level, .ch_level,
		.outside_event_pin, .sample_strobe, .analog_channel_source);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// count conversions mid-cycle, away from the edge
	always @(negedge clk_sys) if (convert_start === 1'b1) conv_n++;
	// -------------------------------------------------
	// shared tasks
	// -------------------------------------------------
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] s, input string nm);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic at_strobe;
		do @(posedge clk_sys); while (sample_strobe !== 1'b1);
	endtask
	// cfg bits: channel 6:4, action 3, edge 2, source 1:0
	task automatic go(input logic [31:0] cfg, input logic [31:0] dly, input logic [31:0] tot);
		bus(1'b1, atc_pkg::ADDR_CFG, cfg);
		bus(1'b1, atc_pkg::ADDR_DELAY, dly);
		bus(1'b1, atc_pkg::ADDR_TOTAL, tot);
		b = conv_n;
		bus(1'b1, atc_pkg::ADDR_CTRL, 32'h0000_0001);
	endtask
	// -------------------------------------------------
	// scenarios
	// -------------------------------------------------
	task automatic t_regs;
		bus(1'b0, atc_pkg::ADDR_DELAY, 32'h0);
		chk(atc_pkg::DELAY_RST, rd, "delay");
		bus(1'b0, atc_pkg::ADDR_TOTAL, 32'h0);
		chk(atc_pkg::TOTAL_RST, rd, "total");
		bus(1'b0, 6'h3C, 32'h0);
		chk(atc_pkg::BUS_UNMAPPED, rd, "unmapped");
		bus(1'b1, atc_pkg::ADDR_DELAY, 32'h0);
		bus(1'b0, atc_pkg::ADDR_DELAY, 32'h0);
		chk(32'h0000_0001, rd, "delay min");
		bus(1'b1, atc_pkg::ADDR_DELAY, 32'hFFFF_FFFF);
		bus(1'b0, atc_pkg::ADDR_DELAY, 32'h0);
		chk(32'hFFFF_FFFF, rd, "delay wide");
	endtask
	task automatic t_free;
		// edge and action set on purpose: must be ignored without a source
		go(32'h0000_000C, 32'h0000_0005, 32'h0000_0003);
		cyc(80);
		chk(3, conv_n - b, "free conversions");
		chk(1'b0, acq_active, "free window");
		bus(1'b0, atc_pkg::ADDR_COUNT, 32'h0);
		chk(3, rd, "sample count");
	endtask
	task automatic t_stop;
		go(32'h0, 32'h0000_0001, 32'h0);
		cyc(60);
		chk(1'b1, acq_active, "unlimited window");
		bus(1'b1, atc_pkg::ADDR_CTRL, 32'h0000_0002);
		b = conv_n;
		cyc(40);
		chk(0, conv_n - b, "after stop");
	endtask
	task automatic t_dstart(input logic e);
		pin_level <= e;
		cyc(10);
		go({28'h0, 1'b0, e, 2'h2}, 32'h0000_0002, 32'h0000_0002);
		cyc(40);
		chk(0, conv_n - b, "armed conversions");
		at_strobe;
		pin_level <= !e;
		b = conv_n;
		// first strobe after the trigger is only the first delay pulse
		cyc(12);
		chk(0, conv_n - b, "during delay");
		cyc(68);
		chk(2, conv_n - b, "delayed start count");
		chk(1'b0, acq_active, "delayed start end");
	endtask
	task automatic t_analog(input logic e);
		// 1000 mV threshold; range e halves full scale, so the levels of
		// each case sit on either side of the mapped code only
		ch_level <= e ? 16'h1C20 : 16'h0BB8;
		bus(1'b1, atc_pkg::ADDR_THRESH, 32'h0000_03E8);
		go({22'h0, 1'b0, e, 1'b0, 3'h3, 1'b0, e, 2'h1}, 32'h0000_0001, 32'h0000_0002);
		cyc(40);
		chk(0, conv_n - b, "analog armed");
		at_strobe;
		ch_level <= e ? 16'h1838 : 16'h0E10;
		b = conv_n;
		cyc(60);
		chk(2, conv_n - b, "analog crossing");
	endtask
	task automatic t_dstop;
		pin_level <= 1'b0;
		cyc(10);
		go(32'h0000_000A, 32'h0000_0003, 32'h0);
		cyc(40);
		chk(1'b1, acq_active, "pretrigger window");
		chk(1'b1, conv_n > b, "pretrigger samples");
		at_strobe;
		pin_level <= 1'b1;
		b = conv_n;
		at_strobe;
		pin_level <= 1'b0;
		at_strobe;
		pin_level <= 1'b1;
		cyc(60);
		chk(3, conv_n - b, "post trigger count");
		chk(1'b0, acq_active, "self stop");
		bus(1'b0, atc_pkg::ADDR_STATUS, 32'h0);
		chk(32'h0000_0021, rd, "status");
	endtask
	task automatic t_buf;
		sample_ready <= 1'b0;
		ch_level <= 16'h1234;
		go(32'h0, 32'h0000_0001, 32'h0);
		cyc(60);
		chk(2, conv_n - b, "full buffer");
		chk(1'b1, sample_valid, "held sample");
		chk(16'h1234, sample_data, "held data");
		bus(1'b1, atc_pkg::ADDR_CTRL, 32'h0000_0002);
		sample_ready <= 1'b1;
		cyc(4);
		chk(1'b0, sample_valid, "drained");
	endtask
	// -------------------------------------------------
	// run control
	// -------------------------------------------------
	task automatic complete_run;
		if (fail_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// watchdog well beyond the thousand or so cycles the scenarios need
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		complete_run;
	end
	initial begin
		{nrst, avs_read, avs_write, strobe_en, pin_level} = 5'h0;
		sample_ready = 1'b1;
		avs_address = 6'h0;
		avs_writedata = 32'h0;
		ch_level = 16'h0;
		{fail_count, check_count, conv_n, b} = 0;
		cyc(4);
		nrst <= 1'b1;
		cyc(1);
		strobe_en <= 1'b1;
		t_regs;
		t_free;
		t_stop;
		t_dstart(1'b0);
		t_dstart(1'b1);
		t_analog(1'b0);
		t_analog(1'b1);
		t_dstop;
		t_buf;
		complete_run;
	end
endmodule

// ---- test/atc_source.sv ----
/*
 * atc_source: far-side model, trigger pin and analog channels.
 * assumes: strobe period 8 cycles; all channels carry ch_level.
 */
`timescale 1ns/100ps
module atc_source (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic strobe_en,
	input wire logic pin_level,
	input wire logic [15:0] ch_level,
	output logic outside_event_pin,
	output logic sample_strobe,
	output logic [127:0] analog_channel_source
);
	// -------------------------------------------------
	// strobe divider
	// -------------------------------------------------
	logic [2:0] div_q; // cycle count inside one strobe period
	logic [2:0] div_d;
	// free counter; a fixed period lets the bench align triggers
	always_comb begin
		div_d = strobe_en ? div_q + 3'h1 : 3'h0;
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			div_q <= 3'h0;
		end else begin
			div_q <= div_d;
		end
	end
	assign sample_strobe = strobe_en && (div_q == 3'h7);
	// pin level passes through untouched, as a plain ttl driver
	assign outside_event_pin = pin_level;
	assign analog_channel_source = {8{ch_level}};
endmodule

// ---- test/atc_top_asserts.sv ----
/*
 * atc_top_asserts: port checker for atc_top.
 * assumes: bound onto atc_top; reset async active low.
 */
`timescale 1ns/100ps
module atc_top_asserts #(
	parameter int DW = 16
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire logic convert_start,
	input wire logic sample_strobe,
	input wire logic acq_active,
	input wire logic [DW-1:0] sample_data,
	input wire logic sample_valid,
	input wire logic sample_ready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// -------------------------------------------------
	// shadow of the configuration word
	// -------------------------------------------------
	logic [3:0] cfg_q; // source, edge, action
	logic [3:0] cfg_d;
	logic wr_ok; // write taken this edge
	logic start_w;
	logic stop_w;
	assign wr_ok = avs_write && !avs_waitrequest;
	assign start_w = wr_ok && avs_address == atc_pkg::ADDR_CTRL && avs_writedata[0];
	assign stop_w = wr_ok && avs_address == atc_pkg::ADDR_CTRL && avs_writedata[1];
	// track cfg so mode-dependent checks know the mode
	always_comb begin
		cfg_d = cfg_q;
		if (wr_ok && avs_address == atc_pkg::ADDR_CFG) begin
			cfg_d = avs_writedata[3:0];
		end
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cfg_q <= 4'h0;
		end else begin
			cfg_q <= cfg_d;
		end
	end
	// -------------------------------------------------
	// assertions
	// -------------------------------------------------
	a_conv_in_window: assert property (convert_start |-> acq_active && sample_strobe)
		else $error("convert start outside window or without strobe");
	a_conv_fills_buf: assert property (convert_start |=> sample_valid)
		else $error("converted sample not offered downstream");
	a_buf_holds_word: assert property (sample_valid && !sample_ready |=>
		sample_valid && $stable(sample_data))
		else $error("stalled sample lost or changed");
	a_stop_closes: assert property (stop_w |=> ##[0:2] !acq_active)
		else $error("stop command did not close window");
	a_free_opens: assert property (start_w && cfg_q[1:0] == 2'h0 |=> ##[0:2] acq_active)
		else $error("free run did not open window");
	a_armed_closed: assert property (start_w && !acq_active && cfg_q[1:0] != 2'h0
		&& !cfg_q[3] |=> !acq_active [*2])
		else $error("delayed start opened without trigger");
	a_stop_mode_opens: assert property (start_w && cfg_q[1:0] != 2'h0 && cfg_q[3]
		|=> ##[0:2] acq_active)
		else $error("delayed stop mode did not sample at start");
	a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest)
		else $error("register access not answered in one wait cycle");
	c_start: cover property (start_w);
	c_conv: cover property (convert_start);
	c_stall: cover property (sample_valid && !sample_ready);
endmodule
bind atc_top atc_top_asserts #(.DW(DW)) i_chk (.clk_sys, .nrst, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_waitrequest, .convert_start, .sample_strobe,
	.acq_active, .sample_data, .sample_valid, .sample_ready);
